// file: core/status_pkg.sv
// constants shared by the status reporting and error queue block
package status_pkg;
   localparam int   ERR_DEPTH           = 10;
   localparam int   CODE_W              = 11;
   localparam logic [10:0] CODE_NO_ERROR     = 11'h000;
   localparam logic [10:0] CODE_RANGE        = 11'h723;
   localparam logic [10:0] CODE_BUF_OVERRUN  = 11'h6A2;
   localparam logic [10:0] CODE_QUE_OVERFLOW = 11'h6B6;
   localparam logic [10:0] CODE_PULSE_TMO    = 11'h12E;
   localparam logic [10:0] CODE_CURR_TRIP    = 11'h141;
   localparam int   STB_ERRQ_BIT        = 2;
   localparam int   STB_QUES_BIT        = 3;
   localparam int   STB_MAV_BIT         = 4;
   localparam int   STB_ESB_BIT         = 5;
   localparam int   STB_MSS_BIT         = 6;
   localparam int   ESR_OPC_BIT         = 0;
   localparam int   ESR_QYE_BIT         = 2;
   localparam int   ESR_DDE_BIT         = 3;
   localparam int   ESR_EXE_BIT         = 4;
   localparam int   ESR_CME_BIT         = 5;
   localparam int   ESR_PON_BIT         = 7;
   localparam logic [7:0] SRE_RESET     = 8'h00;
   localparam logic [7:0] ESE_RESET     = 8'h00;
   localparam logic [7:0] ESR_RESET     = 8'h80;
   localparam logic [7:0] ESR_USED_MASK = 8'hBD;
   localparam logic [7:0] STB_USED_MASK = 8'h7C;
   typedef enum logic [1:0] {
      OPC_IDLE  = 2'b00,
      OPC_WAIT  = 2'b01,
      OPC_QWAIT = 2'b11
   } opc_state_t;
endpackage

// file: core/error_queue.sv
// ten-deep error queue with overflow entry and locking
module error_queue #(
   parameter int DEPTH = status_pkg::ERR_DEPTH,
   parameter int W     = status_pkg::CODE_W
) (
   input  wire logic         clock_in,
   input  wire logic         rst_in,
   input  wire logic         clear_in,
   input  wire logic         push_in,
   input  wire logic [W-1:0] push_code_in,
   input  wire logic         pop_in,
   output logic [W-1:0]      head_out,
   output logic              not_empty_out
);
   localparam int PW = $clog2(DEPTH + 1);
   initial begin
      if (DEPTH < 2 || W < 11) $error("error_queue: bad DEPTH or W");
   end

   logic [W-1:0]  slot_reg [DEPTH];
   logic [PW-1:0] count_reg;
   logic          locked_reg;
   logic          do_pop;
   logic          do_push;
   logic          overflow;

   assign do_pop   = pop_in && (count_reg != '0);
   assign do_push  = push_in && !locked_reg;
   assign overflow = do_push && !do_pop && (count_reg == PW'(DEPTH));

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         count_reg  <= '0;
         locked_reg <= 1'b0;
         for (int i = 0; i < DEPTH; i++) begin
            slot_reg[i] <= '0;
         end
      end else if (clear_in) begin
         // an error arriving with the clear survives it as the only entry
         count_reg  <= push_in ? PW'(1) : '0;
         locked_reg <= 1'b0;
         if (push_in) begin
            slot_reg[0] <= push_code_in;
         end
      end else begin
         if (overflow) begin
            slot_reg[DEPTH-1] <= status_pkg::CODE_QUE_OVERFLOW;
            locked_reg        <= 1'b1;
         end else begin
            // shift toward slot 0 on a read, oldest always at slot 0
            for (int i = 0; i < DEPTH; i++) begin
               if (do_pop && i < DEPTH - 1 && PW'(i + 1) < count_reg) begin
                  slot_reg[i] <= slot_reg[i+1];
               end
            end
            if (do_push) begin
               if (do_pop) begin
                  slot_reg[count_reg - PW'(1)] <= push_code_in;
               end else begin
                  slot_reg[count_reg] <= push_code_in;
               end
            end
            if (do_pop && !do_push) begin
               count_reg <= count_reg - PW'(1);
               locked_reg <= 1'b0;
            end else if (do_push && !do_pop) begin
               count_reg <= count_reg + PW'(1);
            end
         end
      end
   end

   // head is read straight from the slots so back-to-back reads never see a stale entry
   assign head_out      = (count_reg == '0) ? status_pkg::CODE_NO_ERROR : slot_reg[0];
   assign not_empty_out = (count_reg != '0);
endmodule // error_queue

// file: core/status_report.sv
// status byte, standard event latch, enables, operation complete and error queue
module status_report #(
   parameter int DEPTH = status_pkg::ERR_DEPTH
) (
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   input  wire logic        sre_write_in,
   input  wire logic        ese_write_in,
   input  wire logic [7:0]  write_data_in,
   input  wire logic        sre_query_in,
   input  wire logic        stb_query_in,
   input  wire logic        ese_query_in,
   input  wire logic        esr_query_in,
   input  wire logic        err_query_in,
   input  wire logic        cls_in,
   input  wire logic        opc_cmd_in,
   input  wire logic        opc_query_in,
   input  wire logic        inst_reset_in,
   input  wire logic        sys_clear_in,
   input  wire logic        ops_pending_in,
   input  wire logic        ques_summary_in,
   input  wire logic        msg_avail_in,
   input  wire logic        query_err_in,
   input  wire logic        device_err_in,
   input  wire logic        exec_err_in,
   input  wire logic        cmd_err_in,
   input  wire logic        param_range_err_in,
   input  wire logic        buf_overrun_in,
   input  wire logic        pulse_timeout_in,
   input  wire logic        curr_trip_in,
   output logic             resp_valid_out,
   output logic [7:0]       resp_byte_out,
   output logic             err_valid_out,
   output logic [10:0]      err_code_out,
   output logic             opc_resp_out,
   output logic [7:0]       stb_out,
   output logic             srq_out
);
   initial begin
      if (DEPTH != status_pkg::ERR_DEPTH) $error("status_report: queue depth must be ten");
   end

   ////////////////////////////////////////////////////////////////////////////
   // enables and event latch

   logic [7:0]  sre_reg;
   logic [7:0]  ese_reg;
   logic [7:0]  esr_reg;
   logic [7:0]  esr_set;
   logic        opc_done;
   logic [7:0]  stb_now;
   logic [10:0] head_code;
   logic        err_not_empty;
   logic        push_err;
   logic [10:0] push_code;
   status_pkg::opc_state_t opc_state_reg;
   status_pkg::opc_state_t opc_state_next;

   // instrument reset is not used; enables change only on rst_in or a write
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         sre_reg <= status_pkg::SRE_RESET;
         ese_reg <= status_pkg::ESE_RESET;
      end else begin
         if (sre_write_in) begin
            sre_reg <= write_data_in;
         end
         if (ese_write_in) begin
            ese_reg <= write_data_in;
         end
      end
   end

   always_comb begin
      esr_set = 8'h00;
      esr_set[status_pkg::ESR_OPC_BIT] = opc_done;
      esr_set[status_pkg::ESR_QYE_BIT] = query_err_in;
      esr_set[status_pkg::ESR_DDE_BIT] = device_err_in;
      esr_set[status_pkg::ESR_EXE_BIT] = exec_err_in;
      esr_set[status_pkg::ESR_CME_BIT] = cmd_err_in;
   end

   // a new event in the clearing cycle survives the clear
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         esr_reg <= status_pkg::ESR_RESET;
      end else if (esr_query_in || cls_in) begin
         esr_reg <= esr_set & status_pkg::ESR_USED_MASK;
      end else begin
         esr_reg <= (esr_reg | esr_set) & status_pkg::ESR_USED_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // operation complete

   assign opc_done = (opc_state_reg == status_pkg::OPC_WAIT) && !ops_pending_in;

   always_comb begin
      opc_state_next = opc_state_reg;
      case (opc_state_reg)
         status_pkg::OPC_IDLE: begin
            if (opc_query_in) begin
               opc_state_next = status_pkg::OPC_QWAIT;
            end else if (opc_cmd_in) begin
               opc_state_next = status_pkg::OPC_WAIT;
            end
         end
         status_pkg::OPC_WAIT: begin
            if (!ops_pending_in) begin
               opc_state_next = status_pkg::OPC_IDLE;
            end
         end
         status_pkg::OPC_QWAIT: begin
            if (!ops_pending_in) begin
               opc_state_next = status_pkg::OPC_IDLE;
            end
         end
         default: begin
            opc_state_next = status_pkg::OPC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         opc_state_reg <= status_pkg::OPC_IDLE;
         opc_resp_out  <= 1'b0;
      end else begin
         opc_state_reg <= opc_state_next;
         opc_resp_out  <= (opc_state_reg == status_pkg::OPC_QWAIT) && !ops_pending_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // error sources, priority lowest code index first

   always_comb begin
      push_err  = 1'b1;
      push_code = status_pkg::CODE_NO_ERROR;
      if (param_range_err_in) begin
         push_code = status_pkg::CODE_RANGE;
      end else if (buf_overrun_in) begin
         push_code = status_pkg::CODE_BUF_OVERRUN;
      end else if (pulse_timeout_in) begin
         push_code = status_pkg::CODE_PULSE_TMO;
      end else if (curr_trip_in) begin
         push_code = status_pkg::CODE_CURR_TRIP;
      end else begin
         push_err = 1'b0;
      end
   end

   // only rst_in and system clear flush it; inst_reset_in is deliberately not wired here
   error_queue #(
      .DEPTH (DEPTH),
      .W     (status_pkg::CODE_W)
   ) u_queue (
      .clock_in      (clock_in),
      .rst_in        (rst_in),
      .clear_in      (sys_clear_in),
      .push_in       (push_err),
      .push_code_in  (push_code),
      .pop_in        (err_query_in),
      .head_out      (head_code),
      .not_empty_out (err_not_empty)
   );

   ////////////////////////////////////////////////////////////////////////////
   // status byte and responses

   always_comb begin
      stb_now = 8'h00;
      stb_now[status_pkg::STB_ERRQ_BIT] = err_not_empty;
      stb_now[status_pkg::STB_QUES_BIT] = ques_summary_in;
      stb_now[status_pkg::STB_MAV_BIT]  = msg_avail_in;
      stb_now[status_pkg::STB_ESB_BIT]  = |(esr_reg & ese_reg);
      stb_now[status_pkg::STB_MSS_BIT]  = |(stb_now & sre_reg & status_pkg::STB_USED_MASK);
   end

   // status byte is derived live, so clear status drops its event summary bit through the latch
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         stb_out <= 8'h00;
         srq_out <= 1'b0;
      end else begin
         stb_out <= stb_now;
         srq_out <= stb_now[status_pkg::STB_MSS_BIT];
      end
   end

   // one query per cycle expected; priority picks one if several arrive
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         resp_valid_out <= 1'b0;
         resp_byte_out  <= 8'h00;
      end else begin
         resp_valid_out <= sre_query_in || stb_query_in || ese_query_in || esr_query_in;
         if (sre_query_in) begin
            resp_byte_out <= sre_reg;
         end else if (stb_query_in) begin
            resp_byte_out <= stb_now;
         end else if (ese_query_in) begin
            resp_byte_out <= ese_reg;
         end else if (esr_query_in) begin
            resp_byte_out <= esr_reg;
         end
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         err_valid_out <= 1'b0;
         err_code_out  <= status_pkg::CODE_NO_ERROR;
      end else begin
         err_valid_out <= err_query_in;
         if (err_query_in) begin
            err_code_out <= err_not_empty ? head_code : status_pkg::CODE_NO_ERROR;
         end
      end
   end
endmodule // status_report

// file: sim/host_model.sv
// host side: issues one command or query pulse at a time
module host_model (
   input  wire logic   clock_in,
   output logic [19:0] pulse_out,
   output logic [7:0]  data_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      pulse_out = 20'h00000;
      data_out  = 8'h00;
   end
   // released data shows the inverse so a late sample cannot pass by luck
   task automatic send(input int idx, input logic [7:0] val);
      @(posedge clock_in);
      pulse_out <= 20'h00001 << idx;
      data_out  <= val;
      @(posedge clock_in);
      pulse_out <= 20'h00000;
      data_out  <= ~val;
   endtask
endmodule // host_model

// file: sim/status_report_assertions.sv
// port assertions for the status reporting block
module status_report_assertions (
   input wire logic        clock_in,
   input wire logic        rst_in,
   input wire logic        sre_write_in,
   input wire logic        ese_write_in,
   input wire logic [7:0]  write_data_in,
   input wire logic        sre_query_in,
   input wire logic        stb_query_in,
   input wire logic        ese_query_in,
   input wire logic        err_query_in,
   input wire logic        opc_query_in,
   input wire logic        sys_clear_in,
   input wire logic        ops_pending_in,
   input wire logic        param_range_err_in,
   input wire logic        resp_valid_out,
   input wire logic [7:0]  resp_byte_out,
   input wire logic        err_valid_out,
   input wire logic [10:0] err_code_out,
   input wire logic        opc_resp_out,
   input wire logic [7:0]  stb_out,
   input wire logic        srq_out
);
   logic [7:0] sre_reg;
   logic [7:0] ese_reg;
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) sre_reg <= 8'h00;
      else if (sre_write_in) sre_reg <= write_data_in;
   end
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) ese_reg <= 8'h00;
      else if (ese_write_in) ese_reg <= write_data_in;
   end
   property p_srq; srq_out == stb_out[6]; endproperty
   a_srq: assert property (p_srq) else $error("srq mismatch");
   property p_unused; stb_out[1:0] == 2'h0 && !stb_out[7]; endproperty
   a_unused: assert property (p_unused) else $error("unused summary bit set");
   property p_sre_q; sre_query_in && !sre_write_in |=> resp_valid_out && resp_byte_out == sre_reg; endproperty
   a_sre_q: assert property (p_sre_q) else $error("bad mask answer");
   property p_ese_q;
      ese_query_in && !sre_query_in && !stb_query_in && !ese_write_in |=> resp_valid_out && resp_byte_out == ese_reg;
   endproperty
   a_ese_q: assert property (p_ese_q) else $error("bad event mask answer");
   property p_err_rd; err_query_in |=> err_valid_out; endproperty
   a_err_rd: assert property (p_err_rd) else $error("no error answer");
   property p_codes; err_valid_out |-> err_code_out inside {11'h000, 11'h723, 11'h6A2, 11'h6B6, 11'h12E, 11'h141}; endproperty
   a_codes: assert property (p_codes) else $error("unknown error code");
   property p_errq; param_range_err_in && !sys_clear_in ##1 !err_query_in && !sys_clear_in |=> stb_out[2]; endproperty
   a_errq: assert property (p_errq) else $error("queue bit missing");
   property p_opc_early; opc_resp_out |-> !$past(ops_pending_in); endproperty
   a_opc_early: assert property (p_opc_early) else $error("early completion");
   property p_opc_due; opc_query_in && !ops_pending_in ##1 !ops_pending_in |-> ##[1:3] opc_resp_out; endproperty
   a_opc_due: assert property (p_opc_due) else $error("completion late");
   c_ovf: cover property (err_valid_out && err_code_out == 11'h6B6);
   c_opc: cover property (opc_resp_out);
   c_srq: cover property (srq_out);
endmodule // status_report_assertions
bind status_report status_report_assertions chk_i (.clock_in(clock_in), .rst_in(rst_in),
   .sre_write_in(sre_write_in), .ese_write_in(ese_write_in), .write_data_in(write_data_in),
   .sre_query_in(sre_query_in), .stb_query_in(stb_query_in), .ese_query_in(ese_query_in),
   .err_query_in(err_query_in), .opc_query_in(opc_query_in), .sys_clear_in(sys_clear_in),
   .ops_pending_in(ops_pending_in), .param_range_err_in(param_range_err_in), .resp_valid_out(resp_valid_out),
   .resp_byte_out(resp_byte_out), .err_valid_out(err_valid_out), .err_code_out(err_code_out),
   .opc_resp_out(opc_resp_out), .stb_out(stb_out), .srq_out(srq_out));

// file: sim/tb.sv
// self-checking bench for the status reporting block
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        ops_pending = 1'b0;
   logic [1:0]  lvl = 2'h0;
   logic [19:0] p;
   logic [7:0]  d, r, s, resp_byte_out, stb_out;
   logic        resp_valid_out, err_valid_out, opc_resp_out, srq_out, lk = 1'b0;
   logic [10:0] err_code_out, v;
   logic [10:0] q[$];
   int          fails = 0;
   int          n_compared = 0;
   int          seed = 32'h37fd892e;
   int          k, c;
   always #2 clock_in = ~clock_in;
   host_model host (.clock_in(clock_in), .pulse_out(p), .data_out(d));
   status_report #(.DEPTH(10)) dut (
      .clock_in(clock_in), .rst_in(rst_in), .sre_write_in(p[0]), .ese_write_in(p[1]), .write_data_in(d),
      .sre_query_in(p[2]), .stb_query_in(p[3]), .ese_query_in(p[4]), .esr_query_in(p[5]), .err_query_in(p[6]),
      .cls_in(p[7]), .opc_cmd_in(p[8]), .opc_query_in(p[9]), .inst_reset_in(p[10]), .sys_clear_in(p[11]),
      .ops_pending_in(ops_pending), .ques_summary_in(lvl[0]), .msg_avail_in(lvl[1]), .query_err_in(p[12]),
      .device_err_in(p[13]), .exec_err_in(p[14]), .cmd_err_in(p[15]), .param_range_err_in(p[16]),
      .buf_overrun_in(p[17]), .pulse_timeout_in(p[18]), .curr_trip_in(p[19]), .resp_valid_out(resp_valid_out),
      .resp_byte_out(resp_byte_out), .err_valid_out(err_valid_out), .err_code_out(err_code_out),
      .opc_resp_out(opc_resp_out), .stb_out(stb_out), .srq_out(srq_out));
   function automatic logic [10:0] code_of(input int n);
      case (n)
         0: return 11'(-221);
         1: return 11'(-350);
         2: return 11'(302);
         3: return 11'(321);
         default: return 11'(-330);
      endcase
   endfunction
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic ask(input int i);
      int n;
      n = 0;
      host.send(i, 8'h00);
      #1;
      while (resp_valid_out !== 1'b1 && err_valid_out !== 1'b1 && n < 4) begin
         @(posedge clock_in);
         #1;
         n++;
      end
      v = (i == 6) ? err_code_out : {3'h0, resp_byte_out};
   endtask
   // a locked queue drops arrivals until the next read
   task automatic push(input int n);
      host.send(16 + n, 8'h00);
      if (!lk && q.size() < 10) q.push_back(code_of(n));
      else if (!lk) begin
         q[9] = code_of(4);
         lk = 1'b1;
      end
   endtask
   task automatic drain(input int n);
      logic [10:0] e;
      repeat (n) begin
         ask(6);
         e = (q.size() > 0) ? q.pop_front() : 11'h000;
         lk = 1'b0;
         chk(v, e);
      end
   endtask
   task automatic settle_stb(input logic [10:0] exp);
      repeat (3) @(posedge clock_in);
      #1 chk({2'h0, srq_out, stb_out}, exp);
   endtask
   task automatic opc_count();
      c = 0;
      repeat (6) begin
         @(posedge clock_in);
         #1 c += (opc_resp_out === 1'b1) ? 1 : 0;
      end
   endtask
   // run needs a few hundred cycles; 50000 leaves wide margin
   initial begin
      #200000;
      fails++;
      test_done();
   end
   initial begin
      repeat (6) @(posedge clock_in);
      rst_in <= 1'b0;
      settle_stb(11'h000);
      ask(5); chk(v, 11'h080);
      ask(5); chk(v, 11'h000);
      for (k = 0; k < 6; k++) begin
         r = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($random(seed));
         s = 8'($random(seed));
         host.send(0, r);
         host.send(1, s);
         ask(2); chk(v, {3'h0, r});
         ask(4); chk(v, {3'h0, s});
         ask(2); chk(v, {3'h0, r});
      end
      $display("masks done");
      for (k = 12; k < 16; k++) host.send(k, 8'h00);
      ask(5); chk(v, 11'h03C);
      ask(5); chk(v, 11'h000);
      host.send(1, 8'h04);
      host.send(0, 8'h20);
      host.send(12, 8'h00);
      settle_stb(11'h160);
      ask(3); chk(v, 11'h060);
      ask(3); chk(v, 11'h060);
      host.send(7, 8'h00);
      settle_stb(11'h000);
      ask(2); chk(v, 11'h020);
      ask(4); chk(v, 11'h004);
      @(posedge clock_in) lvl <= 2'h3;
      settle_stb(11'h018);
      @(posedge clock_in) lvl <= 2'h0;
      $display("summary done");
      for (k = 0; k < 4; k++) push(k);
      settle_stb(11'h004);
      host.send(10, 8'h00);
      drain(5);
      for (k = 0; k < 13; k++) push($unsigned($random(seed)) % 4);
      drain(11);
      push(0);
      push(1);
      host.send(11, 8'h00);
      q.delete();
      drain(1);
      $display("queue done");
      @(posedge clock_in) ops_pending <= 1'b1;
      host.send(8, 8'h00);
      repeat (5) @(posedge clock_in);
      ask(5); chk(v, 11'h000);
      @(posedge clock_in) ops_pending <= 1'b0;
      repeat (4) @(posedge clock_in);
      ask(5); chk(v, 11'h001);
      @(posedge clock_in) ops_pending <= 1'b1;
      host.send(9, 8'h00);
      opc_count(); chk(11'(c), 11'h000);
      @(posedge clock_in) ops_pending <= 1'b0;
      opc_count(); chk(11'(c), 11'h001);
      host.send(9, 8'h00);
      opc_count(); chk(11'(c), 11'h001);
      $display("completion done");
      test_done();
   end
endmodule // tb
